//--- design/hrs_pkg.sv
package hrs_pkg;
  // Clock rate and derived cycle scale
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
  // Counter width, enough for the longest load limit
  localparam int unsigned CNT_W = 23;
  // Times in their natural units
  localparam int unsigned T_RECOVER_US = 500;
  localparam int unsigned T_SETTLE_NS = 2000;
  localparam int unsigned T_STRAP_HOLD_NS = 1400;
  localparam int unsigned T_STRAP_SETUP_PS = 16700;
  localparam int unsigned T_ATTACH_MS = 100;
  localparam int unsigned T_EEPROM_US = 99500;
  localparam int unsigned T_SMBUS_MS = 300;
  localparam int unsigned T_REQ_MS = 5;
  // Longest times round down to whole cycles
  localparam int unsigned RECOVER_CYC = T_RECOVER_US * CLK_MHZ;
  localparam int unsigned SETTLE_CYC = T_SETTLE_NS * CLK_MHZ / 1000;
  localparam int unsigned STRAP_HOLD_CYC = T_STRAP_HOLD_NS * CLK_MHZ / 1000;
  localparam int unsigned ATTACH_CYC = T_ATTACH_MS * 1000 * CLK_MHZ;
  localparam int unsigned EEPROM_CYC = T_EEPROM_US * CLK_MHZ;
  localparam int unsigned SMBUS_CYC = T_SMBUS_MS * 1000 * CLK_MHZ;
  localparam int unsigned REQ_CYC = T_REQ_MS * 1000 * CLK_MHZ;
  // Least time rounds up, never below one cycle
  localparam int unsigned STRAP_SETUP_RAW = (T_STRAP_SETUP_PS * CLK_MHZ + 999_999) / 1_000_000;
  localparam int unsigned STRAP_SETUP_CYC = (STRAP_SETUP_RAW < 1) ? 1 : STRAP_SETUP_RAW;
  // Configuration source selection
  localparam logic [1:0] MODE_STRAP = 2'h0;
  localparam logic [1:0] MODE_EEPROM = 2'h1;
  localparam logic [1:0] MODE_SMBUS = 2'h2;
  // Reset values
  localparam logic [6:0] ADDR_DEFAULT = 7'h00;
  localparam logic [3:0] PORTS_OFF = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ZERO = 23'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 23'h000001;
  // Start-up sequencer states
  typedef enum logic [1:0] {
    ST_RECOVER = 2'b00,
    ST_LOAD = 2'b01,
    ST_ATTACH = 2'b10,
    ST_RUN = 2'b11
  } hrs_state_t;
endpackage

//--- design/hrs_sequencer.sv
`timescale 1ns/1ns
module hrs_sequencer #(
  parameter logic [hrs_pkg::CNT_W-1:0] RECOVER_LIMIT = hrs_pkg::CNT_W'(hrs_pkg::RECOVER_CYC),
  parameter logic [hrs_pkg::CNT_W-1:0] EEPROM_LIMIT = hrs_pkg::CNT_W'(hrs_pkg::EEPROM_CYC),
  parameter logic [hrs_pkg::CNT_W-1:0] SMBUS_LIMIT = hrs_pkg::CNT_W'(hrs_pkg::SMBUS_CYC),
  parameter logic [hrs_pkg::CNT_W-1:0] REQ_LIMIT = hrs_pkg::CNT_W'(hrs_pkg::REQ_CYC)
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [1:0] cfg_mode,
  input wire logic self_powered,
  input wire logic pll_locked,
  input wire logic cfg_load_done,
  input wire logic usb_bus_reset,
  input wire logic usb_suspend,
  input wire logic set_addr_valid,
  input wire logic [6:0] set_addr_value,
  input wire logic set_config_valid,
  input wire logic set_config_value,
  input wire logic [3:0] port_power_req,
  input wire logic [3:0] port_reset_req,
  input wire logic [3:0] led_on,
  input wire logic [3:0] strap_indicator_pins_i,
  input wire logic req_start,
  input wire logic req_done,
  output logic osc_enable,
  output logic pll_enable,
  output logic phy_enable,
  output logic operational,
  output logic cfg_load_req,
  output logic cfg_from_eeprom,
  output logic cfg_load_timeout,
  output logic usb_attach,
  output logic xact_enable,
  output logic [6:0] dev_addr,
  output logic configured,
  output logic [3:0] port_power_enable,
  output logic [3:0] port_enable,
  output logic [3:0] port_reset,
  output logic tt_flush,
  output logic suspended,
  output logic [3:0] strap_cfg,
  output logic [3:0] strap_indicator_pins_o,
  output logic [3:0] strap_indicator_pins_oe,
  output logic req_timeout
);
  import hrs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State record
  typedef struct packed {
    hrs_state_t st;
    logic [CNT_W-1:0] cnt;
    logic strap_taken;
    logic [3:0] strap;
    logic osc_en;
    logic pll_en;
    logic phy_en;
    logic oper;
    logic load_req;
    logic from_eeprom;
    logic load_to;
    logic attach;
    logic xact_en;
    logic [6:0] addr;
    logic cfgd;
    logic [3:0] pwr;
    logic [3:0] pen;
    logic [3:0] prst;
    logic flush;
    logic susp;
    logic [3:0] led_out;
    logic [3:0] led_oe;
    logic req_busy;
    logic [CNT_W-1:0] req_cnt;
    logic req_to;
  } hrs_regs_t;

  hrs_regs_t s_q;
  hrs_regs_t s_d;
  logic [3:0] led_lvl;
  logic [CNT_W-1:0] load_limit;
  logic load_bounded;

  // Strap high means active-low LED, so the idle level follows the strap
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_led
      assign led_lvl[gi] = s_q.strap[gi] ? ~led_on[gi] : led_on[gi];
    end
  endgenerate

  // Load limit depends on source; self-powered SMBus waits without bound
  // limits
  assign load_limit = (cfg_mode == MODE_EEPROM) ? EEPROM_LIMIT : SMBUS_LIMIT;
  assign load_bounded = (cfg_mode == MODE_EEPROM) || !self_powered;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.flush = 1'b0;
    s_d.req_to = 1'b0;
    s_d.osc_en = 1'b1;
    s_d.pll_en = 1'b1;
    unique case (s_q.st)
      ST_RECOVER: begin
        if (!s_q.strap_taken) begin
          s_d.strap = strap_indicator_pins_i;
          s_d.strap_taken = 1'b1;
        end
        if (pll_locked) begin
          s_d.cnt = s_q.cnt + CNT_ONE;
        end
        if (pll_locked && s_q.cnt == CNT_W'(SETTLE_CYC - 1)) begin
          s_d.phy_en = 1'b1;
          s_d.led_oe = 4'hf;
        end
        if (pll_locked && s_q.cnt == RECOVER_LIMIT - CNT_ONE) begin
          s_d.oper = 1'b1;
          s_d.cnt = CNT_ZERO;
          s_d.from_eeprom = (cfg_mode == MODE_EEPROM);
          if (cfg_mode == MODE_STRAP) begin
            s_d.st = ST_ATTACH;
          end else begin
            s_d.st = ST_LOAD;
            s_d.load_req = 1'b1;
          end
        end
      end
      ST_LOAD: begin
        if (pll_locked) begin
          s_d.cnt = s_q.cnt + CNT_ONE;
        end
        if (cfg_load_done) begin
          s_d.load_req = 1'b0;
          s_d.st = ST_ATTACH;
        end else if (load_bounded && pll_locked && s_q.cnt == load_limit - CNT_ONE) begin
          // Stuck source: fall back to ROM defaults rather than hang
          s_d.load_req = 1'b0;
          s_d.load_to = 1'b1;
          s_d.from_eeprom = 1'b0;
          s_d.st = ST_ATTACH;
        end
      end
      ST_ATTACH: begin
        s_d.attach = 1'b1;
        s_d.xact_en = 1'b1;
        s_d.st = ST_RUN;
      end
      ST_RUN: begin
        if (set_addr_valid) begin
          s_d.addr = set_addr_value;
        end
        if (set_config_valid) begin
          s_d.cfgd = set_config_value;
        end
        s_d.pwr = s_q.cfgd ? port_power_req : PORTS_OFF;
        s_d.susp = usb_suspend;
        if (s_q.req_busy) begin
          s_d.req_cnt = s_q.req_cnt + CNT_ONE;
          if (req_done) begin
            s_d.req_busy = 1'b0;
          end else if (s_q.req_cnt == REQ_LIMIT - CNT_ONE) begin
            s_d.req_busy = 1'b0;
            s_d.req_to = 1'b1;
          end
        end else if (req_start) begin
          s_d.req_busy = 1'b1;
          s_d.req_cnt = CNT_ZERO;
        end
        if (usb_bus_reset) begin
          s_d.addr = ADDR_DEFAULT;
          s_d.cfgd = 1'b0;
          s_d.pwr = PORTS_OFF;
          s_d.flush = 1'b1;
          s_d.susp = 1'b0;
          s_d.req_busy = 1'b0;
        end
      end
    endcase
    s_d.pen = s_d.pwr;
    s_d.prst = port_reset_req & s_d.pen;
    s_d.led_out = led_lvl;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset drops everything to constants
  // reset defaults
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state record
  assign osc_enable = s_q.osc_en;
  assign pll_enable = s_q.pll_en;
  assign phy_enable = s_q.phy_en;
  assign operational = s_q.oper;
  assign cfg_load_req = s_q.load_req;
  assign cfg_from_eeprom = s_q.from_eeprom;
  assign cfg_load_timeout = s_q.load_to;
  assign usb_attach = s_q.attach;
  assign xact_enable = s_q.xact_en;
  assign dev_addr = s_q.addr;
  assign configured = s_q.cfgd;
  assign port_power_enable = s_q.pwr;
  assign port_enable = s_q.pen;
  assign port_reset = s_q.prst;
  assign tt_flush = s_q.flush;
  assign suspended = s_q.susp;
  assign strap_cfg = s_q.strap;
  assign strap_indicator_pins_o = s_q.led_out;
  assign strap_indicator_pins_oe = s_q.led_oe;
  assign req_timeout = s_q.req_to;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Bus reset counts only once attached; earlier pulses are ignored
  sequence bus_rst_run_s;
    usb_bus_reset && s_q.st == ST_RUN;
  endsequence

  // Dark means power and enable both off; a lone enable would still
  // let a downstream device see traffic
  sequence ports_dark_s;
    port_power_enable == PORTS_OFF && port_enable == PORTS_OFF;
  endsequence

  addr_clear_a: assert property (bus_rst_run_s |=> dev_addr == ADDR_DEFAULT && !configured)
    else $error("address or configuration kept over bus reset");
  power_off_a: assert property (bus_rst_run_s |=> ports_dark_s)
    else $error("port power kept over bus reset");
  tt_flush_a: assert property (bus_rst_run_s |=> tt_flush)
    else $error("no buffer flush after bus reset");
  wake_up_a: assert property (bus_rst_run_s |=> !suspended)
    else $error("still suspended after bus reset");
  no_forward_a: assert property (bus_rst_run_s |=> port_reset == PORTS_OFF)
    else $error("bus reset reached a downstream port");
  recover_cnt_a: assert property (s_q.st == ST_RECOVER |-> s_q.cnt < RECOVER_LIMIT)
    else $error("recovery ran past its bound");
  settle_a: assert property (s_q.st == ST_RECOVER && pll_locked
      && s_q.cnt == CNT_W'(SETTLE_CYC - 1) |=> phy_enable && strap_indicator_pins_oe == 4'hf)
    else $error("outputs not settled in time");
  attach_a: assert property (s_q.st == ST_ATTACH |=> usb_attach && xact_enable && s_q.st == ST_RUN)
    else $error("attach not signalled after configuration");
  load_bound_a: assert property (s_q.st == ST_LOAD && load_bounded |-> s_q.cnt < load_limit)
    else $error("configuration load ran past its bound");
  req_bound_a: assert property (s_q.req_busy |-> s_q.req_cnt < REQ_LIMIT)
    else $error("request watchdog ran past its bound");
  strap_hold_a: assert property ($rose(s_q.strap_taken) |-> s_q.cnt <= CNT_W'(STRAP_HOLD_CYC))
    else $error("strap sampled outside the hold window");
  dark_early_a: assert property (s_q.st == ST_RECOVER |-> (ports_dark_s and !usb_attach))
    else $error("ports live before operational");
endmodule

//--- verification/hrs_host_model.sv
`timescale 1ns/1ns
// Upstream host and configuration source, seen from the sequencer's pins
module hrs_host_model #(
  parameter int LOAD_DLY = 10,
  parameter int HOST_WAIT = 20
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic [3:0] strap_lvl,
  input wire logic [3:0] pins_o,
  input wire logic [3:0] pins_oe,
  input wire logic cfg_load_req,
  input wire logic usb_attach,
  input wire logic bus_reset_cmd,
  output logic [3:0] pins_i,
  output logic cfg_load_done,
  output logic usb_bus_reset
);
  int load_cnt;
  int attach_cnt;
  logic pend;
  ////////////////////////////////////////
  // straps held steady
  // Strap resistors set the level whenever the pin is released
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pins_i[i] = pins_oe[i] ? pins_o[i] : strap_lvl[i];
    end
  end
  // load finishes late
  // A stalled source never finishes, which only a stall scenario asks for
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      load_cnt <= 0;
      cfg_load_done <= 1'b0;
    end else begin
      load_cnt <= (cfg_load_req && !stall) ? load_cnt + 1 : 0;
      cfg_load_done <= cfg_load_req && !stall && load_cnt >= LOAD_DLY;
    end
  end
  // host waits after attach
  // A requested bus reset is held back until attach has stood long enough
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      attach_cnt <= 0;
      pend <= 1'b0;
      usb_bus_reset <= 1'b0;
    end else begin
      attach_cnt <= usb_attach ? attach_cnt + 1 : 0;
      usb_bus_reset <= 1'b0;
      if (bus_reset_cmd) pend <= 1'b1;
      if ((pend || bus_reset_cmd) && attach_cnt >= HOST_WAIT) begin
        usb_bus_reset <= 1'b1;
        pend <= 1'b0;
      end
    end
  end
endmodule

//--- verification/hrs_sequencer_tb.sv
`timescale 1ns/1ns
module hrs_sequencer_tb;
  import hrs_pkg::*;
  logic clk_sys, rst_n, self_powered, pll_locked, cfg_load_done, usb_bus_reset, usb_suspend;
  logic set_addr_valid, set_config_valid, set_config_value, req_start, req_done;
  logic stall, bus_reset_cmd, osc_enable, pll_enable, phy_enable, operational, cfg_load_req;
  logic cfg_from_eeprom, cfg_load_timeout, usb_attach, xact_enable, configured, tt_flush;
  logic suspended, req_timeout;
  logic [1:0] cfg_mode;
  logic [6:0] set_addr_value, dev_addr;
  logic [3:0] port_power_req, port_reset_req, led_on, strap_lvl, pins_i, pins_o, pins_oe;
  logic [3:0] port_power_enable, port_enable, port_reset, strap_cfg;
  int fails, tests_run, n;
  ////////////////////////////////////////
  // Short limits keep the run brief: recovery 50, EEPROM 60, SMBus 80, request 30
  hrs_sequencer #(.RECOVER_LIMIT(23'h000032), .EEPROM_LIMIT(23'h00003c),
    .SMBUS_LIMIT(23'h000050), .REQ_LIMIT(23'h00001e)) hrs_sequencer_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .cfg_mode(cfg_mode), .self_powered(self_powered), .pll_locked(pll_locked),
    .cfg_load_done(cfg_load_done), .usb_bus_reset(usb_bus_reset), .usb_suspend(usb_suspend),
    .set_addr_valid(set_addr_valid), .set_addr_value(set_addr_value),
    .set_config_valid(set_config_valid), .set_config_value(set_config_value),
    .port_power_req(port_power_req), .port_reset_req(port_reset_req), .led_on(led_on),
    .strap_indicator_pins_i(pins_i), .req_start(req_start), .req_done(req_done),
    .osc_enable(osc_enable), .pll_enable(pll_enable), .phy_enable(phy_enable),
    .operational(operational), .cfg_load_req(cfg_load_req), .cfg_from_eeprom(cfg_from_eeprom),
    .cfg_load_timeout(cfg_load_timeout), .usb_attach(usb_attach), .xact_enable(xact_enable),
    .dev_addr(dev_addr), .configured(configured), .port_power_enable(port_power_enable),
    .port_enable(port_enable), .port_reset(port_reset), .tt_flush(tt_flush),
    .suspended(suspended), .strap_cfg(strap_cfg), .strap_indicator_pins_o(pins_o),
    .strap_indicator_pins_oe(pins_oe), .req_timeout(req_timeout));
  hrs_host_model hrs_host_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .stall(stall),
    .strap_lvl(strap_lvl), .pins_o(pins_o), .pins_oe(pins_oe), .cfg_load_req(cfg_load_req),
    .usb_attach(usb_attach), .bus_reset_cmd(bus_reset_cmd), .pins_i(pins_i),
    .cfg_load_done(cfg_load_done), .usb_bus_reset(usb_bus_reset));
  // 20 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////
  // Shared compare, bounded wait and verdict
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  function logic pick(input int s);
    case (s)
      0: pick = operational;
      1: pick = usb_attach;
      2: pick = cfg_load_timeout;
      3: pick = tt_flush;
      default: pick = req_timeout;
    endcase
  endfunction
  // A wait that runs out counts as a mismatch and ends the run
  task wait_on(input int s, input int lim);
    n = 0;
    while (pick(s) !== 1'b1) begin
      if (n >= lim) begin
        fails++;
        $display("[FAIL] %0t wait %0d ran out", $time, s);
        summarize();
      end
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask
  ////////////////////////////////////////
  // Hardware reset, then recovery to operational
  task boot(input logic [1:0] m, input logic sp, input logic stl);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    cfg_mode <= m;
    self_powered <= sp;
    stall <= stl;
    led_on <= 4'h0;
    repeat (20) @(posedge clk_sys);
    #1;
    chk({osc_enable, pll_enable}, 8'h00);
    chk({phy_enable, xact_enable, usb_attach}, 8'h00);
    chk({port_power_enable, port_enable}, 8'h00);
    chk({configured, dev_addr}, 8'h00);
    chk({4'h0, pins_oe}, 8'h00);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk({osc_enable, pll_enable}, 8'h03);
    chk({4'h0, strap_cfg}, 8'h0a);
    wait_on(0, 60);
    chk({7'h0, n >= 47 && n <= 51}, 8'h01);
    chk({phy_enable, 3'h0, pins_oe}, 8'h8f);
    chk({4'h0, pins_o}, 8'h0a);
  endtask
  task t_strap;
    boot(MODE_STRAP, 1'b0, 1'b0);
    chk({7'h0, cfg_load_req}, 8'h00);
    wait_on(1, 3);
    chk({usb_attach, xact_enable}, 8'h03);
    @(posedge clk_sys);
    led_on <= 4'hf;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({4'h0, pins_o}, 8'h05);
    $display("strap start-up done");
  endtask
  task t_load(input logic [1:0] m, input logic sp, input logic stl, input int lim);
    boot(m, sp, stl);
    chk({7'h0, cfg_load_req}, 8'h01);
    if (stl) begin
      wait_on(2, lim);
      chk({7'h0, n >= lim - 10}, 8'h01);
    end
    wait_on(1, stl ? 5 : 20);
    chk({cfg_from_eeprom, cfg_load_timeout}, {6'h0, m == MODE_EEPROM && !stl, stl});
    $display("load mode %0d stall %0d done", m, stl);
  endtask
  task t_selfpow;
    boot(MODE_SMBUS, 1'b1, 1'b1);
    repeat (100) @(posedge clk_sys);
    #1;
    chk({cfg_load_timeout, usb_attach}, 8'h00);
    @(posedge clk_sys);
    stall <= 1'b0;
    wait_on(1, 20);
    chk({cfg_from_eeprom, cfg_load_timeout}, 8'h00);
    $display("self-powered load done");
  endtask
  task t_busreset;
    @(posedge clk_sys);
    {set_addr_valid, set_config_valid, set_config_value, usb_suspend} <= 4'hf;
    set_addr_value <= 7'h2a;
    port_power_req <= 4'hf;
    @(posedge clk_sys);
    {set_addr_valid, set_config_valid} <= 2'h0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk({configured, dev_addr}, 8'haa);
    chk({port_power_enable, port_enable}, 8'hff);
    chk({7'h0, suspended}, 8'h01);
    @(posedge clk_sys);
    port_reset_req <= 4'hf;
    bus_reset_cmd <= 1'b1;
    @(posedge clk_sys);
    bus_reset_cmd <= 1'b0;
    #1;
    chk({4'h0, port_reset}, 8'h0f);
    wait_on(3, 30);
    chk({configured, dev_addr}, 8'h00);
    chk({port_power_enable, port_enable}, 8'h00);
    chk({7'h0, suspended}, 8'h00);
    @(posedge clk_sys);
    #1;
    chk({3'h0, tt_flush, port_reset}, 8'h00);
    @(posedge clk_sys);
    {usb_suspend, port_reset_req} <= 5'h00;
    $display("bus reset done");
  endtask
  task t_request;
    logic seen;
    @(posedge clk_sys);
    req_start <= 1'b1;
    @(posedge clk_sys);
    req_start <= 1'b0;
    repeat (5) @(posedge clk_sys);
    req_done <= 1'b1;
    @(posedge clk_sys);
    req_done <= 1'b0;
    seen = 1'b0;
    repeat (40) begin
      @(posedge clk_sys);
      #1;
      seen |= req_timeout;
    end
    chk({7'h0, seen}, 8'h00);
    @(posedge clk_sys);
    req_start <= 1'b1;
    @(posedge clk_sys);
    req_start <= 1'b0;
    wait_on(4, 40);
    chk({7'h0, n >= 26}, 8'h01);
    @(posedge clk_sys);
    req_start <= 1'b1;
    @(posedge clk_sys);
    req_start <= 1'b0;
    boot(MODE_STRAP, 1'b0, 1'b0);
    seen = 1'b0;
    repeat (40) begin
      @(posedge clk_sys);
      #1;
      seen |= req_timeout;
    end
    chk({7'h0, seen}, 8'h00);
    $display("requests done");
  endtask
  // Counters must stand still until the PLL reports lock
  task t_pll;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    pll_locked <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (60) @(posedge clk_sys);
    #1;
    chk({operational, phy_enable}, 8'h00);
    @(posedge clk_sys);
    pll_locked <= 1'b1;
    wait_on(0, 60);
    chk({7'h0, n >= 47 && n <= 51}, 8'h01);
    $display("pll wait done");
  endtask
  ////////////////////////////////////////
  initial begin
    fails = 0;
    tests_run = 0;
    rst_n = 1'b0;
    {self_powered, usb_suspend, set_addr_valid, set_config_valid, set_config_value} = 5'h00;
    {req_start, req_done, stall, bus_reset_cmd} = 4'h0;
    pll_locked = 1'b1;
    cfg_mode = MODE_STRAP;
    set_addr_value = 7'h00;
    {port_power_req, port_reset_req, led_on} = 12'h000;
    strap_lvl = 4'ha;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_strap();
    t_load(MODE_EEPROM, 1'b0, 1'b0, 0);
    t_load(MODE_EEPROM, 1'b0, 1'b1, 65);
    t_load(MODE_SMBUS, 1'b0, 1'b1, 85);
    t_selfpow();
    t_busreset();
    t_request();
    t_pll();
    summarize();
  end
endmodule
